// file: core/qpcg_core.sv
// phase generator, fetch/execute pipeline sequencer and reset state
`timescale 1ns/1ps
module qpcg_core #(
	parameter int DIR_W = 8
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire qpcg_pkg::qpcg_osc_type oscSelect,
	input wire logic extExecMode,
	input wire qpcg_pkg::qpcg_rstcause_type rstCause,
	input wire logic sleepWake,
	input wire logic [15:0] progData,
	input wire logic [7:0] dataRdIn,
	input wire logic [7:0] dirWrData,
	input wire logic dirWrEn,
	input wire logic [7:0] keepWrData,
	input wire logic keepWrEn,
	output logic [3:0] phase,
	output logic clkOut,
	output logic clkOutEn,
	output logic [15:0] progAddr,
	output logic [15:0] instrReg,
	output logic execValid,
	output logic dataRdStb,
	output logic dataWrStb,
	output logic [7:0] dataWrOut,
	output logic [DIR_W-1:0] portDir,
	output logic latchEnable,
	output logic outputEnable_n,
	output logic writeStrobe_n,
	output logic strobeEn,
	output qpcg_pkg::qpcg_flags_type statusFlags,
	output logic [7:0] keepReg
);
	import qpcg_pkg::*;

	typedef struct packed {
		qpcg_phase_type ph;
		logic clkOut;
		logic clkOutEn;
		logic [15:0] pc;
		logic [15:0] fetchWord;
		logic [15:0] ir;
		logic irValid;
		logic flush;
		logic rdStb;
		logic wrStb;
		logic [7:0] operand;
		logic [7:0] wrData;
		logic [DIR_W-1:0] dir;
		logic ale;
		logic oeN;
		logic wrN;
		logic strobeEn;
		qpcg_flags_type flags;
		logic held;
	} qpcg_core_state_type;

	qpcg_core_state_type st_r, st_nxt;
	logic [7:0] keep_r;
	logic anyReset;
	logic ostStart;
	logic ostBusy;
	logic xtalMode;
	logic isJump;

	// =====================================================
	// mode and reset source decode
	assign xtalMode = (oscSelect == OSC_LOW_FREQ_XTAL) || (oscSelect == OSC_STD_XTAL);
	assign anyReset = rstCause.powerOn | rstCause.brownout | rstCause.masterClear | rstCause.watchdog;
	assign ostStart = rstCause.powerOn | rstCause.brownout |
		(xtalMode & ((rstCause.masterClear & rstCause.inSleep) | sleepWake));

	// a jump is only honoured from an instruction that is really executed
	assign isJump = st_r.irValid && (st_r.ir[OP_HI:OP_LO] == JUMP_OP);

	// =====================================================
	// start-up hold, counts oscillator periods after power-up or wake
	qpcg_ost u_ost (
		.mclk(mclk),
		.arst_n(arst_n),
		.start(ostStart),
		.busy(ostBusy)
	);

	// =====================================================
	// next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdStb = 1'b0;
		st_nxt.wrStb = 1'b0;
		st_nxt.clkOutEn = (oscSelect == OSC_EXT_CLOCK) || (oscSelect == OSC_RES_CAP);
		// phase, pc, ir, port direction and bus strobes sit at reset values while a source or the start-up hold is active; fetchWord, operand and wrData keep theirs
		if (anyReset || ostBusy) begin
			st_nxt.ph = PH_ONE;
			st_nxt.held = 1'b1;
			st_nxt.clkOut = 1'b0;
			st_nxt.pc = PC_RESET;
			st_nxt.ir = IR_RESET;
			st_nxt.irValid = 1'b0;
			st_nxt.flush = 1'b0;
			st_nxt.dir = '1;
			st_nxt.strobeEn = extExecMode;
			st_nxt.ale = 1'b0;
			st_nxt.oeN = 1'b1;
			st_nxt.wrN = 1'b1;
			if (anyReset) begin
				// power-on dominates, then brown-out, then the watchdog and sleep qualifiers
				st_nxt.flags.powerOnN = 1'b1;
				st_nxt.flags.brownoutN = 1'b1;
				st_nxt.flags.timeoutN = 1'b1;
				st_nxt.flags.powerdownN = 1'b1;
				if (rstCause.powerOn) begin
					st_nxt.flags.powerOnN = 1'b0;
					st_nxt.flags.brownoutN = 1'b0;
				end else if (rstCause.brownout) begin
					st_nxt.flags.brownoutN = 1'b0;
				end else begin
					if (rstCause.watchdog) begin
						st_nxt.flags.timeoutN = 1'b0;
					end
					if (rstCause.inSleep) begin
						st_nxt.flags.powerdownN = 1'b0;
					end
				end
			end
		end else begin
			st_nxt.held = 1'b0;
			if (dirWrEn) begin
				st_nxt.dir = DIR_W'(dirWrData);
			end
			unique case (st_r.ph)
				PH_ONE: begin
					st_nxt.ph = PH_TWO;
				end
				PH_TWO: begin
					st_nxt.ph = PH_THREE;
					st_nxt.clkOut = 1'b1;
				end
				PH_THREE: begin
					st_nxt.ph = PH_FOUR;
				end
				PH_FOUR: begin
					st_nxt.ph = PH_ONE;
					st_nxt.clkOut = 1'b0;
				end
			endcase
			// pipeline actions on entry to each phase
			// fetch of the next word overlaps execution of the current one
			unique case (st_nxt.ph)
				PH_ONE: begin
					st_nxt.pc = st_r.pc + 16'h0001;
					st_nxt.ir = st_r.fetchWord;
					st_nxt.irValid = ~st_r.flush;
					st_nxt.flush = 1'b0;
				end
				PH_TWO: begin
					st_nxt.rdStb = st_r.irValid;
					st_nxt.operand = dataRdIn;
				end
				PH_THREE: begin
					st_nxt.wrData = st_r.operand;
				end
				PH_FOUR: begin
					st_nxt.fetchWord = progData;
					st_nxt.wrStb = st_r.irValid;
					if (isJump) begin
						st_nxt.pc = {2'h0, st_r.ir[TGT_HI:TGT_LO]};
						st_nxt.flush = 1'b1;
					end
				end
			endcase
		end
	end

	// =====================================================
	// state register
	// pin reset parks the phase in phase_one like any other reset source
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
			st_r.ph <= PH_ONE;
			st_r.held <= 1'b1;
			st_r.dir <= '1;
			st_r.oeN <= 1'b1;
			st_r.wrN <= 1'b1;
			st_r.flags <= '1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// =====================================================
	// reset-immune storage
	// unaffected by any reset, so no reset branch
	always_ff @(posedge mclk) begin
		if (keepWrEn) begin
			keep_r <= keepWrData;
		end
	end

	// =====================================================
	// outputs, all straight from the state register except keepReg, which comes from keep_r
	assign phase = st_r.ph;
	assign clkOut = st_r.clkOut;
	assign clkOutEn = st_r.clkOutEn;
	assign progAddr = st_r.pc;
	assign instrReg = st_r.ir;
	assign execValid = st_r.irValid;
	assign dataRdStb = st_r.rdStb;
	assign dataWrStb = st_r.wrStb;
	assign dataWrOut = st_r.wrData;
	assign portDir = st_r.dir;
	assign latchEnable = st_r.ale;
	assign outputEnable_n = st_r.oeN;
	assign writeStrobe_n = st_r.wrN;
	assign strobeEn = st_r.strobeEn;
	assign statusFlags = st_r.flags;
	assign keepReg = keep_r;

endmodule // qpcg_core

// file: core/qpcg_pkg.sv
// package for the quadrature phase clock generator
// Notes on behaviour
// - oscillator divided by four into four non-overlapping phases forming one instruction cycle
// - program counter advances once per instruction cycle at phase_one
// - fetched word captured at phase_four, moved to instruction register at next phase_one
// - decode and execute happen in phase_two through phase_four
// - operand read in phase_two, destination write in phase_four
// - fetch of next overlaps execution of current, one instruction per cycle
// - program counter change takes two cycles, prefetched word is discarded
// - external clock mode drives divided clock of four oscillator periods
// - resistor-capacitor mode outputs oscillator divided by four
// - reset forces every port direction bit to one
// - during reset phase generator holds phase_one
// - reset in external modes drives latch enable low, output enable and write high
// - reset cause reported through timeout, powerdown, power-on and brownout flags
// - reset-immune registers keep contents, others take reset values except fetchWord, operand and wrData under a source reset
// - two osc_select_bits choose one of four oscillator modes
// - crystal modes hold reset 1024 oscillator periods after power-up or wake
package qpcg_pkg;

	// =====================================================
	// oscillator modes
	typedef enum logic [1:0] {
		OSC_LOW_FREQ_XTAL = 2'h0,
		OSC_STD_XTAL = 2'h1,
		OSC_EXT_CLOCK = 2'h2,
		OSC_RES_CAP = 2'h3
	} qpcg_osc_type;

	// =====================================================
	// phases, one-hot
	typedef enum logic [3:0] {
		PH_ONE = 4'h1,
		PH_TWO = 4'h2,
		PH_THREE = 4'h4,
		PH_FOUR = 4'h8
	} qpcg_phase_type;

	// =====================================================
	// reset causes
	typedef struct packed {
		logic powerOn;
		logic brownout;
		logic masterClear;
		logic watchdog;
		logic inSleep;
	} qpcg_rstcause_type;

	typedef struct packed {
		logic powerOnN;
		logic brownoutN;
		logic timeoutN;
		logic powerdownN;
	} qpcg_flags_type;

	// =====================================================
	// constants
	localparam int OST_PERIODS = 1024;
	localparam logic [10:0] OST_COUNT = 11'(OST_PERIODS);
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] IR_RESET = 16'h0000;
	localparam logic [7:0] DIR_RESET = 8'hFF;
	localparam logic [1:0] JUMP_OP = 2'h3;
	localparam int OP_HI = 15;
	localparam int OP_LO = 14;
	localparam int TGT_HI = 13;
	localparam int TGT_LO = 0;

endpackage : qpcg_pkg

// file: core/qpcg_ost.sv
// oscillator start-up hold counter
`timescale 1ns/1ps
module qpcg_ost (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic start,
	output logic busy
);
	import qpcg_pkg::*;

	typedef struct packed {
		logic [10:0] cnt;
		logic busy;
	} qpcg_ost_state_type;

	qpcg_ost_state_type st_r, st_nxt;

	// =====================================================
	// count oscillator periods while held
	always_comb begin
		st_nxt = st_r;
		if (start) begin
			st_nxt.cnt = 11'h000;
			st_nxt.busy = 1'b1;
		end else if (st_r.busy) begin
			st_nxt.cnt = st_r.cnt + 11'h001;
			if (st_r.cnt == OST_COUNT - 11'h001) begin
				st_nxt.busy = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign busy = st_r.busy;

endmodule // qpcg_ost

// file: sim/qpcg_assertions.sv
// checker for the phase generator core
`timescale 1ns/1ps
module qpcg_assertions #(
	parameter int DIR_W = 8
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic sleepWake,
	input wire logic extExecMode,
	input wire qpcg_pkg::qpcg_rstcause_type rstCause,
	input wire logic [15:0] progData,
	input wire logic [3:0] phase,
	input wire logic clkOut,
	input wire logic [15:0] progAddr,
	input wire logic [15:0] instrReg,
	input wire logic execValid,
	input wire logic dataRdStb,
	input wire logic dataWrStb,
	input wire logic [DIR_W-1:0] portDir,
	input wire logic latchEnable,
	input wire logic outputEnable_n,
	input wire logic writeStrobe_n,
	input wire logic strobeEn
);
	import qpcg_pkg::*;
	logic inRst;
	assign inRst = rstCause.powerOn | rstCause.brownout | rstCause.masterClear | rstCause.watchdog;
	default clocking @(posedge mclk); endclocking
	// a wake request may start the start-up hold, which parks the pipeline like a reset
	logic wakeHold_r;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wakeHold_r <= 1'b0;
		end else if (sleepWake) begin
			wakeHold_r <= 1'b1;
		end else if (phase == 4'h2) begin
			wakeHold_r <= 1'b0;
		end
	end
	// =====================================================
	// phases, pipeline, divided clock and reset state
	a_phase_onehot: assert property (disable iff (!arst_n) $onehot(phase)) else $error("phase not one-hot");
	a_phase_order: assert property (disable iff (!arst_n || inRst || wakeHold_r)
		phase inside {4'h2, 4'h4} |=> phase == ($past(phase) << 1)) else $error("phase order broken");
	a_pc_step: assert property (disable iff (!arst_n || inRst || wakeHold_r)
		phase == 4'h8 |=> phase == 4'h1 && progAddr == $past(progAddr) + 16'h1) else $error("pc step wrong");
	a_ir_capture: assert property (disable iff (!arst_n || inRst || wakeHold_r)
		phase == 4'h4 |=> ##1 instrReg == $past(progData, 2)) else $error("ir capture wrong");
	a_data_strobes: assert property (disable iff (!arst_n)
		dataRdStb == (phase == 4'h2 && execValid) && dataWrStb == (phase == 4'h8 && execValid))
		else $error("data strobe timing wrong");
	a_jump_flush: assert property (disable iff (!arst_n || inRst || wakeHold_r)
		phase == 4'h1 && execValid && instrReg[15:14] == JUMP_OP
		|-> ##3 progAddr == {2'h0, $past(instrReg[13:0], 3)} ##1 !execValid) else $error("jump flush wrong");
	a_clk_div: assert property (disable iff (!arst_n) clkOut == (phase[2] | phase[3]))
		else $error("divided clock wrong");
	a_reset_hold: assert property (disable iff (!arst_n)
		inRst |=> phase == 4'h1 && portDir == '1) else $error("reset hold wrong");
	a_bus_park: assert property (disable iff (!arst_n)
		inRst |=> !latchEnable && outputEnable_n && writeStrobe_n && strobeEn == $past(extExecMode))
		else $error("bus strobes not parked");
	a_release_phase: assert property (disable iff (inRst) $rose(arst_n) |=> phase == 4'h2)
		else $error("first phase after reset wrong");
endmodule // qpcg_assertions
bind qpcg_core qpcg_assertions #(.DIR_W(DIR_W)) u_qpcg_assertions (.mclk, .arst_n, .sleepWake, .extExecMode, .rstCause,
	.progData, .phase, .clkOut, .progAddr, .instrReg, .execValid, .dataRdStb, .dataWrStb, .portDir,
	.latchEnable, .outputEnable_n, .writeStrobe_n, .strobeEn);

// file: sim/qpcg_prog_mem.sv
// program memory model answering the core's fetch address
`timescale 1ns/1ps
module qpcg_prog_mem (
	input wire logic [15:0] progAddr,
	output logic [15:0] progData
);
	// word 5 jumps to 0x0040, every other word is plain
	assign progData = (progAddr == 16'h0005) ? 16'hC040 : {2'h1, progAddr[13:0]};
endmodule // qpcg_prog_mem

// file: sim/tb_quadrature_phase_clock_gen.sv
// testbench for the quadrature phase clock generator core
`timescale 1ns/1ps
module tb_quadrature_phase_clock_gen;
	import qpcg_pkg::*;
	logic mclk, arst_n, extExecMode, sleepWake, dirWrEn, keepWrEn, clkOut, clkOutEn, execValid;
	logic latchEnable, outputEnable_n, writeStrobe_n, strobeEn;
	qpcg_osc_type oscSelect;
	qpcg_rstcause_type rstCause;
	qpcg_flags_type statusFlags;
	logic [15:0] progData, progAddr, instrReg, expPc;
	logic [7:0] dataRdIn, dirWrData, keepWrData, portDir, keepReg, dataWrOut;
	logic [3:0] phase;
	logic [4:0] cs [5] = '{5'h10, 5'h08, 5'h02, 5'h05, 5'h03};
	logic [3:0] fl [5] = '{4'h3, 4'hB, 4'hD, 4'hE, 4'hC};
	int n_fail, checks, i, n;
	qpcg_core u_qpcg_core (.mclk, .arst_n, .oscSelect, .extExecMode, .rstCause, .sleepWake, .progData,
		.dataRdIn, .dirWrData, .dirWrEn, .keepWrData, .keepWrEn, .phase, .clkOut, .clkOutEn, .progAddr,
		.instrReg, .execValid, .dataRdStb(), .dataWrStb(), .dataWrOut, .portDir, .latchEnable,
		.outputEnable_n, .writeStrobe_n, .strobeEn, .statusFlags, .keepReg);
	qpcg_prog_mem u_qpcg_prog_mem (.progAddr, .progData);
	initial begin
		mclk = 0;
		forever #50 mclk = ~mclk;
	end
	// =====================================================
	// tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task automatic end_of_test;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		#1000000;
		n_fail++;
		end_of_test;
	end
	// =====================================================
	// tests
	initial begin
		arst_n = 0;
		oscSelect = OSC_EXT_CLOCK;
		extExecMode = 1;
		rstCause = '0;
		sleepWake = 0;
		dataRdIn = 8'hA5;
		dirWrData = 8'h0F;
		dirWrEn = 0;
		keepWrData = 8'h5A;
		keepWrEn = 0;
		cyc(5);
		arst_n = 1;
		for (i = 0; i < 8; i++) begin
			cyc(1);
			chk(phase, 4'h1 << ((i + 1) % 4));
		end
		chk(clkOutEn, 1);
		$display("phase test done");
		expPc = 16'h2;
		for (i = 0; i < 10; i++) begin
			chk(progAddr, expPc);
			if (expPc == 16'h6) chk(instrReg, 16'hC040);
			chk(execValid, expPc != 16'h41);
			expPc = (expPc == 16'h6) ? 16'h41 : expPc + 16'h1;
			cyc(4);
		end
		chk(dataWrOut, 8'hA5);
		$display("pipeline test done");
		dirWrEn = 1;
		keepWrEn = 1;
		cyc(1);
		keepWrEn = 0;
		chk(portDir, 8'h0F);
		rstCause.masterClear = 1;
		dirWrData = 8'h33;
		cyc(2);
		chk(portDir, 8'hFF);
		chk(phase, 4'h1);
		chk({latchEnable, outputEnable_n, writeStrobe_n, strobeEn}, 4'h7);
		chk(statusFlags, 4'hF);
		rstCause = '0;
		dirWrEn = 0;
		cyc(2);
		chk(portDir, 8'hFF);
		chk(keepReg, 8'h5A);
		$display("reset state test done");
		for (i = 0; i < 5; i++) begin
			rstCause = cs[i];
			cyc(3);
			chk(statusFlags, fl[i]);
			rstCause = '0;
			for (n = 0; n < 1100 && phase === 4'h1; n++) cyc(1);
			if (i < 2) chk(n >= 1024 && n <= 1026, 1);
		end
		$display("reset cause test done");
		for (i = 0; i < 4; i++) begin
			arst_n = 0;
			oscSelect = qpcg_osc_type'(i);
			cyc(5);
			arst_n = 1;
			cyc(2);
			chk(clkOutEn, i >= 2);
			chk(keepReg, 8'h5A);
		end
		$display("mode test done");
		oscSelect = OSC_STD_XTAL;
		sleepWake = 1;
		cyc(1);
		sleepWake = 0;
		for (n = 0; n < 1100 && phase !== 4'h1; n++) cyc(1);
		for (n = 0; n < 1100 && phase === 4'h1; n++) cyc(1);
		chk(n >= 1020 && n <= 1026, 1);
		chk(phase, 4'h2);
		$display("wake test done");
		end_of_test;
	end
endmodule // tb_quadrature_phase_clock_gen
